// [core/tsq_regs.svh]
// register offsets, field positions, reset values and step encodings
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH

`define TSQ_ADDR_W        8
`define TSQ_DATA_W        16
`define TSQ_PTR_W         5

`define TSQ_OFS_CTRL      8'h00
`define TSQ_OFS_C1LIM     8'h01
`define TSQ_OFS_HOLD      8'h02
`define TSQ_OFS_ADJ       8'h03
`define TSQ_OFS_LIT0      8'h04
`define TSQ_OFS_QPTR      8'h05
`define TSQ_OFS_C1VAL     8'h06
`define TSQ_OFS_QUE_BASE  8'h10
`define TSQ_OFS_QUE_MASK  8'hF0

`define TSQ_CTRL_EN_BIT   0
`define TSQ_CTRL_STRT_BIT 1

`define TSQ_RST_REG16     16'h0000
`define TSQ_RST_PTR       5'h00

`define TSQ_CMD_CTRL      4'h0
`define TSQ_CMD_ADD_COPY  4'h1
`define TSQ_CMD_STRB      3'h1
`define TSQ_CMD_JMP       3'h5
`define TSQ_CMD_JMPC1     3'h7
`define TSQ_OPT_LIT_ADC   4'hE
`define TSQ_TGT_C1LIM     3'h1
`define TSQ_TGT_LIT0      3'h5

`endif

// [core/tsq_pkg.sv]
// types shared by the trigger sequencer register bank
package tsq_pkg;
`include "tsq_regs.svh"

   typedef struct packed {
      logic [`TSQ_ADDR_W-1:0] addr;
      logic [`TSQ_DATA_W-1:0] wdata;
      logic                   wr;
      logic                   rd;
   } tsq_req_s;

   typedef struct packed {
      logic [3:0] cmd;
      logic [3:0] opt;
   } tsq_step_s;

   typedef enum logic {
      TSQ_IDLE,
      TSQ_EXEC
   } tsq_state_e;

endpackage

// [core/tsq_reg16.sv]
// one software register with lock-gated write and hardware load port
`timescale 1ns/1ps
module tsq_reg16 #(
   parameter int          WIDTH     = 16,
   parameter logic [15:0] RST_VALUE = 16'h0000
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             clk_en,
   // software side, already gated by the lock
   input  wire logic             sw_we,
   input  wire logic [WIDTH-1:0] sw_data,
   // step engine side
   input  wire logic             hw_we,
   input  wire logic [WIDTH-1:0] hw_data,
   // contents
   output logic      [WIDTH-1:0] value
);
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         value <= RST_VALUE[WIDTH-1:0];
      end else if (clk_en) begin
         // engine only loads while software is locked out, so no contention
         if (hw_we) begin
            value <= hw_data;
         end else if (sw_we) begin
            value <= sw_data;
         end
      end
   end
endmodule

// [core/tsq_step_queue.sv]
// step queue storage: pairs of command bytes, untouched by reset
`timescale 1ns/1ps
module tsq_step_queue #(
   parameter int DEPTH = 16,
   parameter int IDX_W = 4
) (
   // clock
   input  wire logic             clk_sys,
   input  wire logic             clk_en,
   // software pair port
   input  wire logic             we,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [15:0]      wr_data,
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [15:0]      rd_pair,
   // engine byte port
   input  wire logic [IDX_W:0]   step_idx,
   output logic      [7:0]       step_byte
);
   logic [15:0] mem [DEPTH];
   logic [15:0] step_pair;

   // no reset branch on purpose: contents survive every reset
   always_ff @(posedge clk_sys) begin
      if (clk_en && we) begin
         mem[wr_idx] <= wr_data;
      end
   end

   assign rd_pair   = mem[rd_idx];
   assign step_pair = mem[step_idx[IDX_W:1]];
   // low byte is the even step, high byte the odd one
   assign step_byte = step_idx[0] ? step_pair[15:8] : step_pair[7:0];
endmodule

// [core/tsq_regs_top.sv]
// trigger sequencer register bank with minimal step engine
`timescale 1ns/1ps
`include "tsq_regs.svh"
module tsq_regs_top #(
   parameter int QUEUE_DEPTH = 16
) (
   // clock, reset, enable
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              clk_en,
   // register port
   input  tsq_pkg::tsq_req_s      sw_req,
   output logic [`TSQ_DATA_W-1:0] rd_data,
   // channel select output
   output logic [`TSQ_DATA_W-1:0] adc_channel_select,
   output logic                   adc_select_load,
   // counter and state
   output logic [`TSQ_DATA_W-1:0] general_counter1,
   output logic                   counter1_at_limit,
   output logic                   sequencer_running
);
   import tsq_pkg::*;

   localparam int IDX_W = $clog2(QUEUE_DEPTH);

   logic                   sequencer_enable;
   logic                   sequencer_start;
   logic                   locked;
   logic                   sw_wr_ok;
   tsq_state_e             state;
   logic [`TSQ_PTR_W-1:0]  step_queue_pointer;
   logic [`TSQ_PTR_W-1:0]  next_ptr;
   logic [15:0]            counter1_limit;
   logic [15:0]            hold_operand;
   logic [15:0]            adjust_operand;
   logic [15:0]            literal_zero;
   logic [15:0]            que_rd_pair;
   logic [7:0]             step_raw;
   tsq_step_s              step;
   logic                   exec;
   logic                   c1lim_load;
   logic                   lit_load;
   logic [15:0]            tgt_value;
   logic                   cnt1_inc;
   logic                   adc_lit_load;
   logic                   adc_strb_load;
   logic                   que_hit;
   logic                   ctrl_we;
   logic                   c1lim_we;
   logic                   hold_we;
   logic                   adj_we;
   logic                   lit_we;
   logic                   ptr_we;
   logic                   que_we;

   assign locked   = sequencer_enable & sequencer_start;
   assign sw_wr_ok = sw_req.wr & ~locked;
   assign que_hit  = (sw_req.addr & `TSQ_OFS_QUE_MASK) == `TSQ_OFS_QUE_BASE;
   assign exec     = (state == TSQ_EXEC) & locked;
   assign step     = step_raw;

   // lock applied in one place; every register except the control bits goes through it
   always_comb begin
      ctrl_we  = 1'b0;
      c1lim_we = 1'b0;
      hold_we  = 1'b0;
      adj_we   = 1'b0;
      lit_we   = 1'b0;
      ptr_we   = 1'b0;
      que_we   = 1'b0;
      if (sw_req.addr == `TSQ_OFS_CTRL) begin
         ctrl_we = sw_req.wr;
      end else if (sw_req.addr == `TSQ_OFS_C1LIM) begin
         c1lim_we = sw_wr_ok;
      end else if (sw_req.addr == `TSQ_OFS_HOLD) begin
         hold_we = sw_wr_ok;
      end else if (sw_req.addr == `TSQ_OFS_ADJ) begin
         adj_we = sw_wr_ok;
      end else if (sw_req.addr == `TSQ_OFS_LIT0) begin
         lit_we = sw_wr_ok;
      end else if (sw_req.addr == `TSQ_OFS_QPTR) begin
         ptr_we = sw_wr_ok;
      end else if (que_hit) begin
         que_we = sw_wr_ok;
      end
   end

   // control bits stay writable so software can always stop the engine
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sequencer_enable <= 1'b0;
         sequencer_start  <= 1'b0;
      end else if (clk_en) begin
         if (ctrl_we) begin
            sequencer_enable <= sw_req.wdata[`TSQ_CTRL_EN_BIT];
            sequencer_start  <= sw_req.wdata[`TSQ_CTRL_STRT_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= TSQ_IDLE;
      end else if (clk_en) begin
         case (state)
            TSQ_IDLE: begin
               if (locked) begin
                  state <= TSQ_EXEC;
               end
            end
            TSQ_EXEC: begin
               if (!locked) begin
                  state <= TSQ_IDLE;
               end
            end
            default: begin
               state <= TSQ_IDLE;
            end
         endcase
      end
   end

   // one step per enabled cycle; no step delay timer in this bank
   always_comb begin
      next_ptr      = step_queue_pointer + `TSQ_PTR_W'(1);
      c1lim_load    = 1'b0;
      lit_load      = 1'b0;
      tgt_value     = 16'h0000;
      cnt1_inc      = 1'b0;
      adc_lit_load  = 1'b0;
      adc_strb_load = 1'b0;
      if (step.cmd == `TSQ_CMD_CTRL) begin
         adc_lit_load = (step.opt == `TSQ_OPT_LIT_ADC);
      end else if (step.cmd == `TSQ_CMD_ADD_COPY) begin
         // option bit 3 picks copy, low bits pick the target
         if (step.opt[3]) begin
            tgt_value = hold_operand;
         end else if (step.opt[2:0] == `TSQ_TGT_C1LIM) begin
            tgt_value = counter1_limit + adjust_operand;
         end else begin
            tgt_value = literal_zero + adjust_operand;
         end
         c1lim_load = (step.opt[2:0] == `TSQ_TGT_C1LIM);
         lit_load   = (step.opt[2:0] == `TSQ_TGT_LIT0);
      end else if (step.cmd[3:1] == `TSQ_CMD_STRB) begin
         adc_strb_load = 1'b1;
      end else if (step.cmd[3:1] == `TSQ_CMD_JMP) begin
         next_ptr = {step.cmd[0], step.opt};
      end else if (step.cmd[3:1] == `TSQ_CMD_JMPC1) begin
         if (general_counter1 != counter1_limit) begin
            cnt1_inc = 1'b1;
            next_ptr = {step.cmd[0], step.opt};
         end
      end
   end

   // pointer wraps at 32 steps; the 16 pairs hold a byte for every one of them
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         step_queue_pointer <= `TSQ_RST_PTR;
      end else if (clk_en) begin
         if (exec) begin
            step_queue_pointer <= next_ptr;
         end else if (ptr_we) begin
            step_queue_pointer <= sw_req.wdata[`TSQ_PTR_W-1:0];
         end
      end
   end

   // counter restarts from zero each time the engine is started
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         general_counter1 <= `TSQ_RST_REG16;
      end else if (clk_en) begin
         if (state == TSQ_IDLE && locked) begin
            general_counter1 <= `TSQ_RST_REG16;
         end else if (exec && cnt1_inc) begin
            general_counter1 <= general_counter1 + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         counter1_at_limit <= 1'b0;
      end else if (clk_en) begin
         counter1_at_limit <= general_counter1 == counter1_limit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         adc_channel_select <= `TSQ_RST_REG16;
         adc_select_load    <= 1'b0;
      end else if (clk_en) begin
         adc_select_load <= exec & (adc_lit_load | adc_strb_load);
         if (exec && adc_lit_load) begin
            adc_channel_select <= literal_zero;
         end else if (exec && adc_strb_load) begin
            adc_channel_select[4:0] <= {step.cmd[0], step.opt};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sequencer_running <= 1'b0;
      end else if (clk_en) begin
         sequencer_running <= locked;
      end
   end

   tsq_reg16 #(.WIDTH(16), .RST_VALUE(`TSQ_RST_REG16)) u_c1lim (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .sw_we   (c1lim_we),
      .sw_data (sw_req.wdata),
      .hw_we   (exec && c1lim_load),
      .hw_data (tgt_value),
      .value   (counter1_limit)
   );

   tsq_reg16 #(.WIDTH(16), .RST_VALUE(`TSQ_RST_REG16)) u_hold (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .sw_we   (hold_we),
      .sw_data (sw_req.wdata),
      .hw_we   (1'b0),
      .hw_data (16'h0000),
      .value   (hold_operand)
   );

   tsq_reg16 #(.WIDTH(16), .RST_VALUE(`TSQ_RST_REG16)) u_adj (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .sw_we   (adj_we),
      .sw_data (sw_req.wdata),
      .hw_we   (1'b0),
      .hw_data (16'h0000),
      .value   (adjust_operand)
   );

   tsq_reg16 #(.WIDTH(16), .RST_VALUE(`TSQ_RST_REG16)) u_lit0 (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clk_en  (clk_en),
      .sw_we   (lit_we),
      .sw_data (sw_req.wdata),
      .hw_we   (exec && lit_load),
      .hw_data (tgt_value),
      .value   (literal_zero)
   );

   tsq_step_queue #(.DEPTH(QUEUE_DEPTH), .IDX_W(IDX_W)) u_queue (
      .clk_sys   (clk_sys),
      .clk_en    (clk_en),
      .we        (que_we),
      .wr_idx    (sw_req.addr[IDX_W-1:0]),
      .wr_data   (sw_req.wdata),
      .rd_idx    (sw_req.addr[IDX_W-1:0]),
      .rd_pair   (que_rd_pair),
      .step_idx  (step_queue_pointer[IDX_W:0]),
      .step_byte (step_raw)
   );

   // reads are never locked; data stands only in the cycle after
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_data <= 16'h0000;
      end else if (clk_en) begin
         rd_data <= 16'h0000;
         if (sw_req.rd) begin
            if (sw_req.addr == `TSQ_OFS_CTRL) begin
               rd_data <= {14'h0000, sequencer_start, sequencer_enable};
            end else if (sw_req.addr == `TSQ_OFS_C1LIM) begin
               rd_data <= counter1_limit;
            end else if (sw_req.addr == `TSQ_OFS_HOLD) begin
               rd_data <= hold_operand;
            end else if (sw_req.addr == `TSQ_OFS_ADJ) begin
               rd_data <= adjust_operand;
            end else if (sw_req.addr == `TSQ_OFS_LIT0) begin
               rd_data <= literal_zero;
            end else if (sw_req.addr == `TSQ_OFS_QPTR) begin
               rd_data <= {11'h000, step_queue_pointer};
            end else if (sw_req.addr == `TSQ_OFS_C1VAL) begin
               rd_data <= general_counter1;
            end else if (que_hit) begin
               rd_data <= que_rd_pair;
            end
         end
      end
   end
endmodule

// [sim/tsq_regs_props.sv]
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`include "tsq_regs.svh"
module tsq_regs_props
   import tsq_pkg::*;
#(
   parameter int QUEUE_DEPTH = 16
) (
   // clock and reset
   input wire logic             clk_sys,
   input wire logic             reset,
   input wire logic             clk_en,
   // register port
   input wire tsq_pkg::tsq_req_s sw_req,
   input wire logic [15:0]      rd_data,
   // engine outputs
   input wire logic [15:0]      adc_channel_select,
   input wire logic             adc_select_load,
   input wire logic [15:0]      general_counter1,
   input wire logic             counter1_at_limit,
   input wire logic             sequencer_running
);
   logic go;
   logic rd_ptr;
   logic rd_cnt;
   assign go = sw_req.wdata[1:0] == 2'h3;
   assign rd_ptr = clk_en && sw_req.rd && sw_req.addr == `TSQ_OFS_QPTR;
   assign rd_cnt = clk_en && sw_req.rd && sw_req.addr == `TSQ_OFS_C1VAL;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   AST_RD_IDLE: assert property (clk_en && !sw_req.rd |=> rd_data == 0)
      else $error("read data not zero outside a read");
   AST_RUN_LEVEL: assert property ((clk_en && sw_req.wr &&
      sw_req.addr == `TSQ_OFS_CTRL ##1 clk_en)
      |=> sequencer_running == $past(go, 2))
      else $error("running flag does not follow control");
   AST_SEL_LOAD: assert property ($changed(adc_channel_select)
      |-> adc_select_load)
      else $error("select changed without load pulse");
   AST_LOAD_RUN: assert property (adc_select_load
      |-> $past(sequencer_running))
      else $error("select loaded while stopped");
   AST_CNT_RUN: assert property ($changed(general_counter1)
      |-> sequencer_running)
      else $error("counter moved while stopped");
   AST_CNT_STEP: assert property ($changed(general_counter1) &&
      general_counter1 != 0 |-> general_counter1 ==
      $past(general_counter1) + 16'h0001)
      else $error("counter did not step by one");
   AST_QPTR_HI: assert property (rd_ptr |=> rd_data[15:5] == 0)
      else $error("pointer upper bits not zero");
   AST_C1_READ: assert property (rd_cnt
      |=> rd_data == $past(general_counter1))
      else $error("counter read mismatch");
   // main scenarios reached
   cover property (adc_select_load);
   cover property ($rose(sequencer_running));
   cover property (counter1_at_limit && sequencer_running);
endmodule

bind tsq_regs_top tsq_regs_props #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_props (
   .clk_sys, .reset, .clk_en, .sw_req, .rd_data, .adc_channel_select,
   .adc_select_load, .general_counter1, .counter1_at_limit,
   .sequencer_running);

// [sim/tsq_regs_tb.sv]
// self-checking bench for the trigger sequencer register bank
`timescale 1ns/1ps
`include "tsq_regs.svh"
module testbench;
   import tsq_pkg::*;
   logic        clk_sys;
   logic        reset;
   logic        clk_en;
   tsq_req_s    sw_req;
   logic [15:0] rd_data;
   logic [15:0] sel;
   logic        load;
   logic [15:0] cnt1;
   logic        at_lim;
   logic        running;
   int          bad_count;
   int          checks;
   logic [15:0] q [16];
   logic [15:0] v [4];

   always #5 clk_sys = ~clk_sys;

   tsq_regs_top #(.QUEUE_DEPTH(16)) uut (
      .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
      .sw_req(sw_req), .rd_data(rd_data), .adc_channel_select(sel),
      .adc_select_load(load), .general_counter1(cnt1),
      .counter1_at_limit(at_lim), .sequencer_running(running));

   task automatic final_report();
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cmp(input string n, input logic [15:0] e,
                      input logic [15:0] s);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   // strobes change just after an edge; the slave never stalls
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
      sw_req.addr <= a;
      sw_req.wdata <= d;
      sw_req.wr <= w;
      sw_req.rd <= !w;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      cmp("rd_data", e, rd_data);
   endtask

   task automatic idle(input int n);
      sw_req.wr <= 1'b0;
      sw_req.rd <= 1'b0;
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wait_load(input logic [15:0] e);
      int i;
      for (i = 0; i < 20; i++) begin
         if (load === 1'b1) break;
         @(posedge clk_sys);
         #1;
      end
      if (i == 20) begin
         bad_count++;
         final_report();
      end else begin
         cmp("adc_channel_select", e, sel);
         @(posedge clk_sys);
         #1;
         cmp("adc_select_load", 16'h0000, 16'(load));
      end
   endtask

   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      clk_en = 1'b1;
      sw_req = '0;
      bad_count = 0;
      checks = 0;
      v = '{16'h0002, 16'h1234, 16'h0101, 16'h00AA};
      for (int k = 0; k < 16; k++) q[k] = {8'(2*k+1), 8'(2*k)};
      // literal, copy, literal, add, literal, loop twice, strobe, park
      q[0] = 16'h1D0E;
      q[1] = 16'h150E;
      q[2] = 16'hE50E;
      q[3] = 16'hA72A;
      repeat (8) @(posedge clk_sys);
      #1;
      reset <= 1'b0;
      for (int k = 1; k < 6; k++) rd(8'(k), 16'h0000);
      for (int k = 0; k < 4; k++) wr(8'(k+1), v[k]);
      for (int k = 0; k < 4; k++) rd(8'(k+1), v[k]);
      wr(`TSQ_OFS_QPTR, 16'hFFFF);
      rd(`TSQ_OFS_QPTR, 16'h001F);
      wr(`TSQ_OFS_QPTR, 16'h0000);
      for (int k = 0; k < 16; k++) wr(8'(16+k), q[k]);
      for (int k = 0; k < 16; k++) rd(8'(16+k), q[k]);
      wr(`TSQ_OFS_CTRL, 16'h0003);
      idle(1);
      wait_load(16'h00AA);
      wait_load(16'h1234);
      wait_load(16'h1335);
      wr(`TSQ_OFS_HOLD, 16'hFFFF);
      rd(`TSQ_OFS_HOLD, 16'h1234);
      idle(1);
      wait_load(16'h132A);
      idle(12);
      cmp("general_counter1", 16'h0002, cnt1);
      cmp("counter1_at_limit", 16'h0001, 16'(at_lim));
      cmp("sequencer_running", 16'h0001, 16'(running));
      wr(`TSQ_OFS_QPTR, 16'h0000);
      rd(`TSQ_OFS_QPTR, 16'h0007);
      rd(`TSQ_OFS_C1VAL, 16'h0002);
      rd(`TSQ_OFS_LIT0, 16'h1335);
      wr(`TSQ_OFS_CTRL, 16'h0000);
      idle(3);
      cmp("sequencer_running", 16'h0000, 16'(running));
      // restart at the parked step: the loop counter starts over
      wr(`TSQ_OFS_CTRL, 16'h0003);
      idle(3);
      cmp("general_counter1", 16'h0000, cnt1);
      wr(`TSQ_OFS_CTRL, 16'h0000);
      idle(3);
      wr(`TSQ_OFS_HOLD, 16'h5555);
      rd(`TSQ_OFS_HOLD, 16'h5555);
      // a frozen clock enable must drop the request
      clk_en <= 1'b0;
      wr(`TSQ_OFS_HOLD, 16'h7777);
      clk_en <= 1'b1;
      idle(1);
      rd(`TSQ_OFS_HOLD, 16'h5555);
      rd(8'h08, 16'h0000);
      reset <= 1'b1;
      idle(8);
      reset <= 1'b0;
      for (int k = 0; k < 16; k++) rd(8'(16+k), q[k]);
      rd(`TSQ_OFS_HOLD, 16'h0000);
      final_report();
   end
endmodule
